/* core/irq_pkg.sv */
// Register map, bit positions and reset values of the interrupt status and mask block.
`default_nettype none

package irq_pkg;

    // Register bus widths.
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // Byte addresses of the two registers.
    localparam logic [7:0] STATUS_ADDR = 8'h0C;
    localparam logic [7:0] MASK_ADDR   = 8'h10;

    // Reset values.
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET   = 32'h8000_0000;

    // Bit positions inside the status and mask registers.
    localparam int unsigned SUMMARY_BIT        = 0;
    localparam int unsigned PHY_IRQ_BIT        = 1;
    localparam int unsigned BUS_RESET_BIT      = 2;
    localparam int unsigned CMD_RESET_BIT      = 3;
    localparam int unsigned SELF_ID_END_BIT    = 4;
    localparam int unsigned PHY_PACKET_BIT     = 5;
    localparam int unsigned BUSY_ACK_SENT_BIT  = 8;
    localparam int unsigned PHY_REG_READ_BIT   = 9;
    localparam int unsigned FIFO_ACCESS_BIT    = 10;
    localparam int unsigned HEADER_CRC_BIT     = 11;
    localparam int unsigned TCODE_ERROR_BIT    = 12;
    localparam int unsigned CYCLE_SECOND_BIT   = 13;
    localparam int unsigned CYCLE_START_BIT    = 14;

    // Status bits that hold sticky event flags; all others except summary bit 0 read as zero.
    localparam logic [31:0] FLAG_BITS = 32'h0000_7F3E;

    // Value returned for an unmapped read.
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // Event vector type, one bit per status position.
    typedef logic [31:0] word_t;

endpackage

`default_nettype wire

/* core/flag_bank_if.sv */
// Interface carrying set, clear and flag vectors between the control logic and the flag bank.
`timescale 1ns/1ps
`default_nettype none

interface flag_bank_if;
    irq_pkg::word_t set_vec;
    irq_pkg::word_t clr_vec;
    irq_pkg::word_t flags;

    // The bank receives set and clear requests and returns the flags.
    modport bank
    (
        input  set_vec,
        input  clr_vec,
        output flags
    );

    // The control side drives requests and reads the flags.
    modport ctrl
    (
        output set_vec,
        output clr_vec,
        input  flags
    );
endinterface

`default_nettype wire

/* core/flag_bank.sv */
// Sticky event flag bank with write-one-to-clear and set-over-clear priority.
`timescale 1ns/1ps
`default_nettype none

module flag_bank
(
    input  wire logic   ref_clk,
    input  wire logic   reset_n,
    flag_bank_if.bank   fb
);

    irq_pkg::word_t flags_ff;
    irq_pkg::word_t nxt_flags;

    // A clear drops only the bits it names, then any new event sets its bit again.
    always_comb
    begin
        nxt_flags = ((flags_ff & ~fb.clr_vec) | fb.set_vec) & irq_pkg::FLAG_BITS; // RULE19
    end

    // A device reset empties the bank, as does a host write of ones to every set flag; a serial bus reset is just another event.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flags_ff <= irq_pkg::STATUS_RESET; // RULE1
        end
        else
        begin
            flags_ff <= nxt_flags; // RULE4
        end
    end

    assign fb.flags = flags_ff;

endmodule

`default_nettype wire

/* core/link_interrupt_status_mask.sv */
// Interrupt status and mask register pair with summary bit and active-low interrupt output.
//
// Summary of operation
// RULE1 - Status clears to zero at device reset; serial bus reset leaves it alone.
// RULE2 - Mask resets to 8000_0000h; serial bus reset leaves it alone.
// RULE3 - A flag reaches the interrupt only while its mask bit is one.
// RULE4 - Flags are recorded and readable even while masked.
// RULE5 - Status bit 0 reads one when any enabled flag is set.
// RULE6 - The interrupt pin is the inverse of the summary bit.
// RULE7 - Bit 1 sets when the PHY signals an interrupt to the link.
// RULE8 - Bit 2 sets when the PHY finishes initialization or sees bus reset.
// RULE9 - Bit 3 sets on a command reset write; receive FIFO stores the packet.
// RULE10 - Bit 4 sets when the link sees the end of self-ID.
// RULE11 - Bit 5 sets when the receiver takes in a PHY packet.
// RULE12 - Bit 8 sets when receive overflow forces a busy acknowledge.
// RULE13 - Bit 9 sets when a PHY register value lands in the access register.
// RULE14 - Bit 10 sets when the transmit FIFO access sequence is violated.
// RULE15 - Bit 11 sets on a header CRC error for a possibly local packet.
// RULE16 - Bit 12 sets when the transmitter finds an invalid transaction code.
// RULE17 - Bit 13 sets when the cycle timer seconds count increments.
// RULE18 - Bit 14 sets when a cycle-start packet is sent or received.
// RULE19 - Flags stay set until the host writes one; writing zero keeps them.
`timescale 1ns/1ps
`default_nettype none

module link_interrupt_status_mask
(
    input  wire logic                        ref_clk,
    input  wire logic                        reset_n,
    // Register port.
    input  wire logic [irq_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [irq_pkg::DATA_W-1:0]  reg_wr_data,
    input  wire logic                        reg_wr_en,
    input  wire logic                        reg_rd_en,
    output logic      [irq_pkg::DATA_W-1:0]  reg_rd_data,
    // One-cycle event strobes from the device's own logic.
    input  wire logic                        phy_irq_evt,
    input  wire logic                        bus_reset_evt,
    input  wire logic                        cmd_reset_evt,
    input  wire logic                        self_id_end_evt,
    input  wire logic                        phy_packet_evt,
    input  wire logic                        busy_ack_sent_evt,
    input  wire logic                        phy_reg_read_evt,
    input  wire logic                        fifo_access_error_evt,
    input  wire logic                        header_crc_error_evt,
    input  wire logic                        tcode_error_evt,
    input  wire logic                        cycle_second_evt,
    input  wire logic                        cycle_start_evt,
    // Interrupt to the host bus interface, low while an enabled flag is pending.
    output logic                             irq_out_n,
    // Level copy of the summary bit for the rest of the device.
    output logic                             irq_summary
);

    // Address decode helper used by both the write and read paths.
    function automatic logic addr_hit
    (
        input logic [irq_pkg::ADDR_W-1:0] addr,
        input logic [irq_pkg::ADDR_W-1:0] target
    );
        addr_hit = (addr == target);
    endfunction

    // Enabled flags reduced to one bit, used for the summary and the pin.
    function automatic logic any_enabled
    (
        input irq_pkg::word_t flags,
        input irq_pkg::word_t mask
    );
        any_enabled = |(flags & mask & irq_pkg::FLAG_BITS);
    endfunction

    flag_bank_if fb ();

    irq_pkg::word_t                 mask_ff;
    logic [irq_pkg::DATA_W-1:0]     rd_data_ff;
    logic                           irq_out_n_ff;
    logic                           summary_ff;
    irq_pkg::word_t                 nxt_set;
    logic                           status_wr;
    logic                           mask_wr;
    logic                           summary_now;

    // Register write decode.
    assign status_wr = reg_wr_en && addr_hit(reg_addr, irq_pkg::STATUS_ADDR);
    assign mask_wr   = reg_wr_en && addr_hit(reg_addr, irq_pkg::MASK_ADDR);

    // Gather the event strobes into their status positions.
    always_comb
    begin
        nxt_set = '0;
        nxt_set[irq_pkg::PHY_IRQ_BIT]       = phy_irq_evt;           // RULE7
        nxt_set[irq_pkg::BUS_RESET_BIT]     = bus_reset_evt;         // RULE8
        nxt_set[irq_pkg::CMD_RESET_BIT]     = cmd_reset_evt;         // RULE9
        nxt_set[irq_pkg::SELF_ID_END_BIT]   = self_id_end_evt;       // RULE10
        nxt_set[irq_pkg::PHY_PACKET_BIT]    = phy_packet_evt;        // RULE11
        nxt_set[irq_pkg::BUSY_ACK_SENT_BIT] = busy_ack_sent_evt;     // RULE12
        nxt_set[irq_pkg::PHY_REG_READ_BIT]  = phy_reg_read_evt;      // RULE13
        nxt_set[irq_pkg::FIFO_ACCESS_BIT]   = fifo_access_error_evt; // RULE14
        nxt_set[irq_pkg::HEADER_CRC_BIT]    = header_crc_error_evt;  // RULE15
        nxt_set[irq_pkg::TCODE_ERROR_BIT]   = tcode_error_evt;       // RULE16
        nxt_set[irq_pkg::CYCLE_SECOND_BIT]  = cycle_second_evt;      // RULE17
        nxt_set[irq_pkg::CYCLE_START_BIT]   = cycle_start_evt;       // RULE18
    end

    // Write-one-to-clear requests go to the flag bank only on a status write.
    assign fb.set_vec = nxt_set;
    assign fb.clr_vec = status_wr ? reg_wr_data : '0; // RULE19

    flag_bank u_flag_bank
    (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .fb      (fb)
    );

    // Mask register; only reset and host writes change it, never a bus reset.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mask_ff <= irq_pkg::MASK_RESET; // RULE2
        end
        else if (mask_wr)
        begin
            mask_ff <= reg_wr_data;
        end
    end

    // Summary of the flags whose mask bits are set.
    assign summary_now = any_enabled(fb.flags, mask_ff); // RULE3

    // Registered summary and inverted pin, one cycle behind the flags.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            summary_ff   <= 1'b0;
            irq_out_n_ff <= 1'b1;
        end
        else
        begin
            summary_ff   <= summary_now;  // RULE5
            irq_out_n_ff <= ~summary_now; // RULE6
        end
    end

    // Read data stands for the cycle after the read strobe only.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_data_ff <= irq_pkg::UNMAPPED_DATA;
        end
        else if (!reg_rd_en)
        begin
            rd_data_ff <= irq_pkg::UNMAPPED_DATA;
        end
        else if (addr_hit(reg_addr, irq_pkg::STATUS_ADDR))
        begin
            rd_data_ff <= fb.flags | {{(irq_pkg::DATA_W-1){1'b0}}, summary_now}; // RULE5
        end
        else if (addr_hit(reg_addr, irq_pkg::MASK_ADDR))
        begin
            rd_data_ff <= mask_ff;
        end
        else
        begin
            rd_data_ff <= irq_pkg::UNMAPPED_DATA;
        end
    end

    assign reg_rd_data = rd_data_ff;
    assign irq_out_n   = irq_out_n_ff;
    assign irq_summary = summary_ff;

endmodule

`default_nettype wire

/* verif/irq_checker_asserts.sv */
// Concurrent checks on the ports of the interrupt status and mask block.
`timescale 1ns/1ps
`default_nettype none

module irq_checker
(
    input wire logic                       ref_clk,
    input wire logic                       reset_n,
    input wire logic [irq_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [irq_pkg::DATA_W-1:0] reg_wr_data,
    input wire logic                       reg_wr_en,
    input wire logic                       reg_rd_en,
    input wire logic [irq_pkg::DATA_W-1:0] reg_rd_data,
    input wire logic                       phy_irq_evt,
    input wire logic                       bus_reset_evt,
    input wire logic                       irq_out_n,
    input wire logic                       irq_summary
);
    irq_pkg::word_t mask_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Shadow of the mask register, rebuilt from the writes seen on the port.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mask_ff <= irq_pkg::MASK_RESET;
        end
        else if (reg_wr_en && reg_addr == irq_pkg::MASK_ADDR)
        begin
            mask_ff <= reg_wr_data;
        end
    end

    // Relations between the port signals that every run must keep.
    chk_pin_inverse: assert property (irq_out_n != irq_summary)
        else $error("interrupt pin is not the inverse of the summary");
    chk_mask_read_back: assert property (
        reg_rd_en && reg_addr == irq_pkg::MASK_ADDR |=> reg_rd_data == mask_ff)
        else $error("mask read differs from the written value");
    chk_reserved_zero: assert property (
        reg_rd_en && reg_addr == irq_pkg::STATUS_ADDR
        |=> (reg_rd_data & ~(irq_pkg::FLAG_BITS | 32'h0000_0001)) == '0)
        else $error("unused status bits read nonzero");
    chk_rd_idle_zero: assert property (!$past(reg_rd_en) |-> reg_rd_data == '0)
        else $error("read data nonzero outside a read answer");
    // The summary port lags the flags by one cycle, so the write that matters is the previous one.
    chk_flag_sticky: assert property (irq_summary && !$past(reg_wr_en) |=> irq_summary)
        else $error("interrupt dropped without a write");
    chk_masked_quiet: assert property (
        (mask_ff & irq_pkg::FLAG_BITS) == '0 && !reg_wr_en |=> !irq_summary)
        else $error("interrupt raised while every flag is masked");
    chk_phy_irq_raise: assert property (
        phy_irq_evt && mask_ff[irq_pkg::PHY_IRQ_BIT] && !reg_wr_en |-> ##2 irq_summary)
        else $error("enabled phy interrupt did not raise the summary");
    chk_bus_reset_raise: assert property (
        bus_reset_evt && mask_ff[irq_pkg::BUS_RESET_BIT] && !reg_wr_en |-> ##2 irq_summary)
        else $error("enabled bus reset did not raise the summary");
endmodule

bind link_interrupt_status_mask irq_checker irq_checker_i
(
    .ref_clk       (ref_clk),
    .reset_n       (reset_n),
    .reg_addr      (reg_addr),
    .reg_wr_data   (reg_wr_data),
    .reg_wr_en     (reg_wr_en),
    .reg_rd_en     (reg_rd_en),
    .reg_rd_data   (reg_rd_data),
    .phy_irq_evt   (phy_irq_evt),
    .bus_reset_evt (bus_reset_evt),
    .irq_out_n     (irq_out_n),
    .irq_summary   (irq_summary)
);

`default_nettype wire

/* verif/host_model.sv */
// Host processor model that drives the register port.
`timescale 1ns/1ps
`default_nettype none

module host_model
(
    input  wire logic        ref_clk,
    output logic      [7:0]  reg_addr,
    output logic      [31:0] reg_wr_data,
    output logic             reg_wr_en,
    output logic             reg_rd_en,
    input  wire logic [31:0] reg_rd_data
);
    initial {reg_addr, reg_wr_data, reg_wr_en, reg_rd_en} = '0;

    // One-cycle write; a one in the data clears that flag, a zero keeps it.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wr_data <= v;
        reg_wr_en <= 1'h1;
        @(posedge ref_clk);
        reg_wr_en <= 1'h0;
    endtask

    // One-cycle read; the answer stands only in the following cycle.
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd_en <= 1'h1;
        @(posedge ref_clk);
        reg_rd_en <= 1'h0;
        #1 v = reg_rd_data;
    endtask
endmodule

`default_nettype wire

/* verif/testbench.sv */
// Self-checking testbench for the interrupt status and mask block.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic                  ref_clk = 1'h0;
    logic                  reset_n = 1'h0;
    logic           [11:0] ev = 12'h000;
    wire logic      [7:0]  reg_addr;
    wire logic      [31:0] reg_wr_data, reg_rd_data;
    wire logic             reg_wr_en, reg_rd_en, irq_out_n, irq_summary;
    wire logic phy_irq_evt, bus_reset_evt, cmd_reset_evt, self_id_end_evt, phy_packet_evt,
        busy_ack_sent_evt, phy_reg_read_evt, fifo_access_error_evt, header_crc_error_evt,
        tcode_error_evt, cycle_second_evt, cycle_start_evt;
    int                    errors = 0;
    int                    compares = 0;
    irq_pkg::word_t        d, b;

    // Event strobes in status bit order.
    assign {cycle_start_evt, cycle_second_evt, tcode_error_evt, header_crc_error_evt,
        fifo_access_error_evt, phy_reg_read_evt, busy_ack_sent_evt, phy_packet_evt,
        self_id_end_evt, cmd_reset_evt, bus_reset_evt, phy_irq_evt} = ev;
    always #50 ref_clk = ~ref_clk;

    link_interrupt_status_mask link_interrupt_status_mask_i
    (
        .ref_clk               (ref_clk),
        .reset_n               (reset_n),
        .reg_addr              (reg_addr),
        .reg_wr_data           (reg_wr_data),
        .reg_wr_en             (reg_wr_en),
        .reg_rd_en             (reg_rd_en),
        .reg_rd_data           (reg_rd_data),
        .phy_irq_evt           (phy_irq_evt),
        .bus_reset_evt         (bus_reset_evt),
        .cmd_reset_evt         (cmd_reset_evt),
        .self_id_end_evt       (self_id_end_evt),
        .phy_packet_evt        (phy_packet_evt),
        .busy_ack_sent_evt     (busy_ack_sent_evt),
        .phy_reg_read_evt      (phy_reg_read_evt),
        .fifo_access_error_evt (fifo_access_error_evt),
        .header_crc_error_evt  (header_crc_error_evt),
        .tcode_error_evt       (tcode_error_evt),
        .cycle_second_evt      (cycle_second_evt),
        .cycle_start_evt       (cycle_start_evt),
        .irq_out_n             (irq_out_n),
        .irq_summary           (irq_summary)
    );
    host_model host_model_i
    (
        .ref_clk     (ref_clk),
        .reg_addr    (reg_addr),
        .reg_wr_data (reg_wr_data),
        .reg_wr_en   (reg_wr_en),
        .reg_rd_en   (reg_rd_en),
        .reg_rd_data (reg_rd_data)
    );

    task automatic check(input string what, input irq_pkg::word_t exp, got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input irq_pkg::word_t exp);
        host_model_i.rd(a, d);
        check("read data", exp, d);
    endtask

    task automatic pulse(input logic [11:0] v);
        @(posedge ref_clk);
        ev <= v;
        @(posedge ref_clk);
        ev <= 12'h000;
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Every event masked, then enabled; set, keep, collide with a clear, clear.
    initial
    begin
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'h1;
        rd_chk(irq_pkg::STATUS_ADDR, irq_pkg::STATUS_RESET);
        rd_chk(irq_pkg::MASK_ADDR, irq_pkg::MASK_RESET);
        rd_chk(8'h14, irq_pkg::UNMAPPED_DATA);
        for (int m = 0; m < 2; m++)
        begin
            host_model_i.wr(irq_pkg::MASK_ADDR, m ? 32'hFFFF_FFFF : irq_pkg::MASK_RESET);
            rd_chk(irq_pkg::MASK_ADDR, m ? 32'hFFFF_FFFF : irq_pkg::MASK_RESET);
            for (int i = 0; i < 12; i++)
            begin
                b = 32'h0000_0001 << (i < 5 ? i + 1 : i + 3);
                pulse(12'h001 << i);
                @(posedge ref_clk);
                #1 check("summary", m, irq_summary);
                check("interrupt pin", !m, irq_out_n);
                rd_chk(irq_pkg::STATUS_ADDR, b | m);
                host_model_i.wr(irq_pkg::STATUS_ADDR, ~b);
                rd_chk(irq_pkg::STATUS_ADDR, b | m);
                fork
                    host_model_i.wr(irq_pkg::STATUS_ADDR, b);
                    pulse(12'h001 << i);
                join
                rd_chk(irq_pkg::STATUS_ADDR, b | m);
                host_model_i.wr(irq_pkg::STATUS_ADDR, b);
                rd_chk(irq_pkg::STATUS_ADDR, 32'h0000_0000);
                check("interrupt pin", 1, irq_out_n);
            end
        end
        pulse(12'h001);
        pulse(12'h002);
        rd_chk(irq_pkg::STATUS_ADDR, 32'h0000_0007);
        rd_chk(irq_pkg::MASK_ADDR, 32'hFFFF_FFFF);
        // Only the bus reset flag enabled: a masked flag must not raise the summary.
        host_model_i.wr(irq_pkg::STATUS_ADDR, 32'h0000_0006);
        host_model_i.wr(irq_pkg::MASK_ADDR, 32'h0000_0004);
        pulse(12'h001);
        @(posedge ref_clk);
        #1 check("summary", 0, irq_summary);
        rd_chk(irq_pkg::STATUS_ADDR, 32'h0000_0002);
        pulse(12'h002);
        @(posedge ref_clk);
        #1 check("summary", 1, irq_summary);
        rd_chk(irq_pkg::STATUS_ADDR, 32'h0000_0007);
        // A device reset in mid-run restores both registers and the pin.
        @(posedge ref_clk);
        reset_n <= 1'h0;
        repeat (2) @(posedge ref_clk);
        #1 check("interrupt pin", 1, irq_out_n);
        check("summary", 0, irq_summary);
        @(posedge ref_clk);
        reset_n <= 1'h1;
        rd_chk(irq_pkg::STATUS_ADDR, irq_pkg::STATUS_RESET);
        rd_chk(irq_pkg::MASK_ADDR, irq_pkg::MASK_RESET);
        finish_test;
    end

    // Cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        finish_test;
    end
endmodule

`default_nettype wire
